//--- pkg/acmp_regs.svh
// Register offsets, bit positions, reset values and timing counts for the
// comparator control block. Assumes a byte-wide register port.
// Summary of operation
// R1: Comparator output passes a two-stage synchronizer before the result bit.
// R2: Mux enable set and converter off: channel select picks negative input pin.
// R3: Bandgap select replaces the positive pin with the bandgap reference.
// R4: Power-off bit removes comparator power; clearing it restores operation.
// R5: Flag sets when a synchronized output event matches the selected mode.
// R6: Flag clears on interrupt acknowledge or a one written to it.
// R7: Request only while flag, enable and global enable are all set.
// R8: Mode 00 toggle, 01 reserved, 10 falling edge, 11 rising edge.
// R9: Capture-route bit connects synchronized result to timer capture input.
// R10: Software clears interrupt enable before changing the power-off bit.
// R11: Software clears interrupt enable before changing the mode bits.
// R12: Edges are found comparing current and previous synchronized values.
`ifndef ACMP_REGS_SVH
`define ACMP_REGS_SVH

`define ACMP_ADDR_W          4
`define ACMP_SFIO_OFFSET     4'h0
`define ACMP_CTRL_OFFSET     4'h1
`define ACMP_IRQ_STAT_OFFSET 4'h2
`define ACMP_IRQ_MASK_OFFSET 4'h3

`define ACMP_SFIO_MUXEN_BIT  3
`define ACMP_CTRL_PWROFF_BIT 7
`define ACMP_CTRL_BG_BIT     6
`define ACMP_CTRL_RESULT_BIT 5
`define ACMP_CTRL_FLAG_BIT   4
`define ACMP_CTRL_IEN_BIT    3
`define ACMP_CTRL_CAP_BIT    2
`define ACMP_CTRL_MODE_HI    1
`define ACMP_CTRL_MODE_LO    0

`define ACMP_SFIO_RESET      8'h00
`define ACMP_CTRL_RESET      8'h00
`define ACMP_MASK_RESET      8'h00
`define ACMP_SYNC_STAGES     2

`endif

//--- pkg/acmp_pkg.sv
// Types shared by the comparator control block.
// Assumes acmp_regs.svh supplies the numeric constants.
package acmp_pkg;
  typedef enum logic [1:0] {
    ACMP_MODE_TOGGLE   = 2'h0,
    ACMP_MODE_RESERVED = 2'h1,
    ACMP_MODE_FALL     = 2'h2,
    ACMP_MODE_RISE     = 2'h3
  } acmp_mode_t;
endpackage

//--- rtl/acmp_sync.sv
// Two-flop level synchronizer for the raw comparator output.
// Assumes the input is asynchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
`include "acmp_regs.svh"
module acmp_sync (
  input  wire logic sys_clk,
  input  wire logic reset,
  input  wire logic async_in,
  output logic      sync_out
);
  logic [`ACMP_SYNC_STAGES-1:0] stage;

  // R1: two-stage synchronizer. Only the second stage is read outside.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      stage <= '0;
    end else begin
      stage <= {stage[`ACMP_SYNC_STAGES-2:0], async_in};
    end
  end

  assign sync_out = stage[`ACMP_SYNC_STAGES-1];
endmodule
`default_nettype wire

//--- rtl/acmp_edge.sv
// Edge detector on the synchronized comparator result with mode matching.
// Assumes the input is already in the sys_clk domain.
`timescale 1ns/1ps
`default_nettype none
module acmp_edge (
  input  wire logic              sys_clk,
  input  wire logic              reset,
  input  wire logic              level_in,
  input  wire acmp_pkg::acmp_mode_t mode,
  output logic                   event_hit
);
  logic prev;

  // R12: previous-cycle copy for edge compare.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      prev <= 1'b0;
    end else begin
      prev <= level_in;
    end
  end

  // R8: mode decode; the reserved code never fires.
  always_comb begin
    case (mode)
      acmp_pkg::ACMP_MODE_TOGGLE: event_hit = level_in ^ prev;
      acmp_pkg::ACMP_MODE_FALL:   event_hit = prev & ~level_in;
      acmp_pkg::ACMP_MODE_RISE:   event_hit = level_in & ~prev;
      default:                    event_hit = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

//--- rtl/acmp_ctrl.sv
// Digital control around an on-chip analog comparator: input selection,
// power control, output synchronization, edge interrupt and capture route.
// Assumes a simple byte register port, read data one cycle after the strobe,
// and analog muxes outside that obey the select outputs driven here.
//
// Decided for this implementation: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "acmp_regs.svh"
module acmp_ctrl (
  input  wire logic                    sys_clk,
  input  wire logic                    reset,
  input  wire logic [`ACMP_ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]              reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [7:0]              reg_rdata,
  input  wire logic                    converter_enable,
  input  wire logic [2:0]              channel_select,
  input  wire logic                    global_irq_enable,
  input  wire logic                    irq_ack,
  input  wire logic                    comparator_raw,
  output logic                         neg_use_channel,
  output logic      [2:0]              neg_channel,
  output logic                         bandgap_select,
  output logic                         comparator_power_off,
  output logic                         capture_in,
  output logic                         comparator_irq,
  output logic                         irq_out
);
  // Software-held control bits, then the flag, synchronized result, event and status state.
  logic                 neg_input_mux_enable;
  logic                 comparator_irq_enable;
  logic                 capture_route_enable;
  acmp_pkg::acmp_mode_t irq_mode;
  logic                 comparator_irq_flag;
  logic                 sync_result;
  logic                 event_hit;
  logic [1:0]           irq_status;
  logic [1:0]           irq_mask;

  // Full-width reset images, so each field takes only its own bits.
  localparam logic [7:0] SFIO_RST = `ACMP_SFIO_RESET;
  localparam logic [7:0] MASK_RST = `ACMP_MASK_RESET;

  // Decode shared by every write and read path.
  function automatic logic hit(input logic [`ACMP_ADDR_W-1:0] a,
                               input logic [`ACMP_ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  logic wr_sfio;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_mask;
  assign wr_sfio = reg_wr & hit(reg_addr, `ACMP_SFIO_OFFSET);
  assign wr_ctrl = reg_wr & hit(reg_addr, `ACMP_CTRL_OFFSET);
  assign wr_stat = reg_wr & hit(reg_addr, `ACMP_IRQ_STAT_OFFSET);
  assign wr_mask = reg_wr & hit(reg_addr, `ACMP_IRQ_MASK_OFFSET);

  // R1: synchronize the raw output before any logic reads it.
  acmp_sync u_sync (
    .sys_clk  (sys_clk),
    .reset    (reset),
    .async_in (comparator_raw),
    .sync_out (sync_result)
  );

  // R5: event matching against the selected mode.
  acmp_edge u_edge (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .level_in  (sync_result),
    .mode      (irq_mode),
    .event_hit (event_hit)
  );

  // Multiplexer enable lives in the special function register.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      neg_input_mux_enable <= SFIO_RST[`ACMP_SFIO_MUXEN_BIT];
    end else if (wr_sfio) begin
      neg_input_mux_enable <= reg_wdata[`ACMP_SFIO_MUXEN_BIT];
    end
  end

  // Control register fields. R10 and R11 are software's duty; no interlock.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      comparator_power_off  <= 1'b0;
      bandgap_select        <= 1'b0;
      comparator_irq_enable <= 1'b0;
      capture_route_enable  <= 1'b0;
      irq_mode              <= acmp_pkg::ACMP_MODE_TOGGLE;
    end else if (wr_ctrl) begin
      // R4: power-off written at any time.
      comparator_power_off  <= reg_wdata[`ACMP_CTRL_PWROFF_BIT];
      // R3: bandgap substitution select.
      bandgap_select        <= reg_wdata[`ACMP_CTRL_BG_BIT];
      comparator_irq_enable <= reg_wdata[`ACMP_CTRL_IEN_BIT];
      capture_route_enable  <= reg_wdata[`ACMP_CTRL_CAP_BIT];
      irq_mode <= acmp_pkg::acmp_mode_t'(
        reg_wdata[`ACMP_CTRL_MODE_HI:`ACMP_CTRL_MODE_LO]);
    end
  end

  // R5: flag set by a matching event; set wins over any clear.
  // R6: cleared by vector acknowledge or a one written to the flag.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      comparator_irq_flag <= 1'b0;
    end else if (event_hit) begin
      comparator_irq_flag <= 1'b1;
    end else if (irq_ack ||
                 (wr_ctrl && reg_wdata[`ACMP_CTRL_FLAG_BIT])) begin
      comparator_irq_flag <= 1'b0;
    end
  end

  // R2: negative input selection, registered toward the analog mux.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      neg_use_channel <= 1'b0;
      neg_channel     <= 3'h0;
    end else begin
      neg_use_channel <= neg_input_mux_enable & ~converter_enable;
      neg_channel     <= channel_select;
    end
  end

  // R9: capture route; held low when the route is off so no edge leaks.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      capture_in <= 1'b0;
    end else begin
      capture_in <= capture_route_enable & sync_result;
    end
  end

  // R7: request needs flag, local enable and global enable together.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      comparator_irq <= 1'b0;
    end else begin
      comparator_irq <= comparator_irq_flag & comparator_irq_enable
                        & global_irq_enable;
    end
  end

  // Sticky status: bit 0 comparator event, bit 1 capture-route edge.
  // Set wins over write-one-to-clear so no event is lost.
  logic cap_prev;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cap_prev <= 1'b0;
    end else begin
      cap_prev <= capture_in;
    end
  end

  logic [1:0] stat_set;
  assign stat_set = {capture_in ^ cap_prev, event_hit};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_stat
      always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
          irq_status[gi] <= 1'b0;
        end else if (stat_set[gi]) begin
          irq_status[gi] <= 1'b1;
        end else if (wr_stat && reg_wdata[gi]) begin
          irq_status[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Mask register of the same layout as the status register.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      irq_mask <= MASK_RST[1:0];
    end else if (wr_mask) begin
      irq_mask <= reg_wdata[1:0];
    end
  end

  // Level interrupt, registered so the top output comes from a flop.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(irq_status & irq_mask);
    end
  end

  // Read data, valid only the cycle after the strobe; zero otherwise.
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    if (hit(reg_addr, `ACMP_SFIO_OFFSET)) begin
      rd_mux[`ACMP_SFIO_MUXEN_BIT] = neg_input_mux_enable;
    end else if (hit(reg_addr, `ACMP_CTRL_OFFSET)) begin
      rd_mux = {comparator_power_off, bandgap_select, sync_result,
                comparator_irq_flag, comparator_irq_enable,
                capture_route_enable, irq_mode};
    end else if (hit(reg_addr, `ACMP_IRQ_STAT_OFFSET)) begin
      rd_mux = {6'h00, irq_status};
    end else if (hit(reg_addr, `ACMP_IRQ_MASK_OFFSET)) begin
      rd_mux = {6'h00, irq_mask};
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule
`default_nettype wire

//--- testbench/acmp_cmp_model.sv
// Behavioural analog comparator beside the control block.
// Assumes the bench moves the input levels just after clock edges.
`timescale 1ns/1ps
`default_nettype none
module acmp_cmp_model (
  input  wire logic pos_above,
  input  wire logic bg_above,
  input  wire logic bandgap_select,
  input  wire logic comparator_power_off,
  output logic      comparator_raw
);
  // unpowered output low
  // An unpowered comparator rests low, so software must mask it first.
  assign comparator_raw = comparator_power_off ? 1'h0 :
                          (bandgap_select ? bg_above : pos_above);
endmodule
`default_nettype wire

//--- testbench/acmp_ctrl_asserts.sv
// Checker on the comparator control block ports.
// Assumes one clock domain and the offsets of acmp_regs.svh.
`timescale 1ns/1ps
`default_nettype none
`include "acmp_regs.svh"
module acmp_ctrl_chk (
  input wire logic       sys_clk,
  input wire logic       reset,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       converter_enable,
  input wire logic [2:0] channel_select,
  input wire logic       global_irq_enable,
  input wire logic       irq_ack,
  input wire logic       comparator_raw,
  input wire logic       neg_use_channel,
  input wire logic [2:0] neg_channel,
  input wire logic       bandgap_select,
  input wire logic       comparator_power_off,
  input wire logic       capture_in,
  input wire logic       comparator_irq
);
  logic ctl_wr;
  // Control register writes, used by several properties.
  assign ctl_wr = reg_wr && reg_addr == `ACMP_CTRL_OFFSET;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  a_power_bit: assert property (ctl_wr |=>
    comparator_power_off == $past(reg_wdata[7])) else $error("power bit");
  a_bandgap_bit: assert property (ctl_wr |=>
    bandgap_select == $past(reg_wdata[6])) else $error("bandgap bit");
  a_neg_gate: assert property (neg_use_channel |->
    !$past(converter_enable)) else $error("negative mux gate");
  a_chan_copy: assert property (neg_use_channel |->
    neg_channel == $past(channel_select)) else $error("channel copy");
  a_irq_gate: assert property (comparator_irq |->
    $past(global_irq_enable)) else $error("global gate");
  a_ien_off: assert property (ctl_wr && !reg_wdata[3] |->
    ##2 !comparator_irq) else $error("enable off");
  a_capture_route: assert property (capture_in |->
    $past(comparator_raw, 3)) else $error("capture path");
  a_ack_clear: assert property (irq_ack &&
    $past(comparator_raw, 2) == $past(comparator_raw, 3)
    |-> ##2 !comparator_irq) else $error("ack clear");
endmodule
bind acmp_ctrl acmp_ctrl_chk u_acmp_ctrl_chk (
  .sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .irq_ack(irq_ack),
  .converter_enable(converter_enable), .channel_select(channel_select),
  .global_irq_enable(global_irq_enable), .capture_in(capture_in),
  .comparator_raw(comparator_raw), .neg_use_channel(neg_use_channel),
  .neg_channel(neg_channel), .bandgap_select(bandgap_select),
  .comparator_power_off(comparator_power_off),
  .comparator_irq(comparator_irq));
`default_nettype wire

//--- testbench/acmp_ctrl_tb_top.sv
// Self-checking bench for the comparator control block.
// Assumes the design, the comparator model and the checker compile first.
`timescale 1ns/1ps
`default_nettype none
`include "acmp_regs.svh"
module acmp_ctrl_tb_top;
  localparam logic [3:0] ctl  = `ACMP_CTRL_OFFSET;
  localparam logic [3:0] stat = `ACMP_IRQ_STAT_OFFSET;
  logic       sys_clk, reset, reg_wr, reg_rd, converter_enable, irq_ack;
  logic       global_irq_enable, comparator_raw, pos_above, bg_above;
  logic       neg_use_channel, bandgap_select, comparator_power_off;
  logic       capture_in, comparator_irq, irq_out, rd_seen, hit;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [2:0] channel_select, neg_channel;
  logic [7:0] exp_q[$];
  int         err_total, checks_done;
  integer     seed;
  acmp_ctrl u_acmp_ctrl (
    .sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .converter_enable(converter_enable),
    .channel_select(channel_select), .global_irq_enable(global_irq_enable),
    .irq_ack(irq_ack), .comparator_raw(comparator_raw),
    .neg_use_channel(neg_use_channel), .neg_channel(neg_channel),
    .bandgap_select(bandgap_select), .capture_in(capture_in),
    .comparator_power_off(comparator_power_off), .irq_out(irq_out),
    .comparator_irq(comparator_irq));
  acmp_cmp_model u_acmp_cmp_model (
    .pos_above(pos_above), .bg_above(bg_above),
    .bandgap_select(bandgap_select), .comparator_raw(comparator_raw),
    .comparator_power_off(comparator_power_off));
  task automatic chk_rd(input logic [7:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic got, exp);
    chk_rd({7'h00, got}, {7'h00, exp});
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'h1;
    @(posedge sys_clk);
    reg_wr    <= 1'h0;
  endtask
  // The expected byte is queued when the read is issued.
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'h1;
    exp_q.push_back(e);
    @(posedge sys_clk);
    reg_rd   <= 1'h0;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic conclude();
    if (exp_q.size() != 0) err_total++;
    $display("checks_done=%0d err_total=%0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    sys_clk = 1'h0;
    forever #4 sys_clk = ~sys_clk;
  end
  // Read data stand only in the cycle after the strobe, so look there.
  always @(posedge sys_clk) begin
    if (rd_seen) chk_rd(reg_rdata, exp_q.pop_front());
    rd_seen <= reg_rd;
  end
  // A hung sequence is cut short and counted as a mismatch.
  initial begin
    repeat (4000) @(posedge sys_clk);
    err_total++;
    conclude();
  end
  initial begin
    seed = 32'hE65E9C25;
    {reg_wr, reg_rd, irq_ack, pos_above, bg_above, rd_seen} = 6'h00;
    {converter_enable, global_irq_enable} = 2'h0;
    {reg_addr, reg_wdata, channel_select} = 15'h0000;
    reset = 1'h1;
    repeat (6) @(posedge sys_clk);
    reset <= 1'h0;
    wr(4'hF, 8'hFF);
    for (int a = 0; a < 5; a++) rd(a == 4 ? 4'hF : 4'(a), 8'h00);
    for (int i = 0; i < 8; i++) begin
      wr(`ACMP_SFIO_OFFSET, {4'h0, i[0], 3'h0});
      @(posedge sys_clk);
      converter_enable <= i[1];
      channel_select   <= 3'($random(seed));
      tick(2);
      chk_pin(neg_use_channel, i[0] & ~i[1]);
      if (i[0] & ~i[1]) chk_rd({5'h00, neg_channel}, {5'h00, channel_select});
    end
    // The interrupt enable stays clear while power and input bits move.
    wr(ctl, 8'h01);
    @(posedge sys_clk);
    pos_above <= 1'h1;
    tick(4);
    rd(ctl, 8'h21);
    wr(ctl, 8'h45);
    tick(4);
    chk_pin(bandgap_select, 1'h1);
    rd(ctl, 8'h45);
    @(posedge sys_clk);
    bg_above <= 1'h1;
    tick(4);
    chk_pin(capture_in, 1'h1);
    rd(ctl, 8'h65);
    wr(ctl, 8'h61);
    tick(2);
    chk_pin(capture_in, 1'h0);
    wr(ctl, 8'hC1);
    tick(4);
    chk_pin(comparator_power_off, 1'h1);
    rd(ctl, 8'hC1);
    wr(ctl, 8'h01);
    tick(4);
    rd(ctl, 8'h21);
    // Each mode sees one falling and one rising comparator edge.
    for (int m = 0; m < 4; m++) begin
      wr(ctl, {3'h0, 1'h1, 2'h0, 2'(m)});
      for (int v = 0; v < 2; v++) begin
        @(posedge sys_clk);
        pos_above <= v[0];
        tick(4);
        hit = (m == 0) || (m == 2 && v == 0) || (m == 3 && v == 1);
        rd(ctl, {2'h0, v[0], hit, 2'h0, 2'(m)});
        wr(ctl, {3'h0, 1'h1, 2'h0, 2'(m)});
      end
    end
    rd(stat, 8'h03);
    wr(stat, 8'h03);
    wr(ctl, 8'h18);
    @(posedge sys_clk);
    global_irq_enable <= 1'h1;
    pos_above <= 1'h0;
    tick(5);
    chk_pin(comparator_irq, 1'h1);
    chk_pin(irq_out, 1'h0);
    wr(`ACMP_IRQ_MASK_OFFSET, 8'h01);
    tick(2);
    chk_pin(irq_out, 1'h1);
    @(posedge sys_clk);
    global_irq_enable <= 1'h0;
    tick(2);
    chk_pin(comparator_irq, 1'h0);
    @(posedge sys_clk);
    global_irq_enable <= 1'h1;
    tick(2);
    chk_pin(comparator_irq, 1'h1);
    @(posedge sys_clk);
    irq_ack <= 1'h1;
    @(posedge sys_clk);
    irq_ack <= 1'h0;
    tick(2);
    chk_pin(comparator_irq, 1'h0);
    rd(ctl, 8'h08);
    wr(stat, 8'h01);
    tick(2);
    chk_pin(irq_out, 1'h0);
    wr(ctl, 8'h00);
    tick(3);
    conclude();
  end
endmodule
`default_nettype wire
